/* File: src/upat_pkg.sv */
package upat_pkg;
    localparam int          NUM_STORES  = 13;
    localparam int          LEN_W       = 24;
    localparam int          LABEL_CHARS = 14;
    localparam int          STEP_ZONES  = 8;
    localparam logic [23:0] MAX_LEN     = 24'h800000;
    localparam logic [23:0] FINE_LIMIT  = 24'h008000;
    localparam logic [23:0] LEN_RESET   = 24'h000001;
    localparam logic [3:0]  NV_FIRST    = 4'h1;
    localparam logic [3:0]  NV_LAST     = 4'h4;
    localparam logic [3:0]  LAST_STORE  = 4'hc;
    localparam logic [3:0]  PACK1       = 4'h1;
    localparam logic [3:0]  PACK8       = 4'h8;
    localparam logic [7:0]  CH_HASH     = 8'h23;
    localparam logic [7:0]  CH_0        = 8'h30;
    localparam logic [7:0]  CH_1        = 8'h31;
    localparam logic [7:0]  CH_9        = 8'h39;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_SEL     = 8'h04;
    localparam logic [7:0]  OFF_USE     = 8'h08;
    localparam logic [7:0]  OFF_LEN     = 8'h0c;
    localparam logic [7:0]  OFF_LABEL0  = 8'h10;
    localparam logic [7:0]  OFF_LABEL3  = 8'h1c;
    localparam logic [7:0]  OFF_FORMAT  = 8'h20;
    localparam logic [7:0]  OFF_CMD     = 8'h24;
    localparam logic [7:0]  OFF_START   = 8'h28;
    localparam logic [7:0]  OFF_COUNT   = 8'h2c;
    localparam logic [7:0]  OFF_DATA    = 8'h30;
    localparam logic [7:0]  OFF_STATUS  = 8'h34;
    localparam logic [7:0]  OFF_QDATA   = 8'h38;
    localparam logic [7:0]  OFF_STAMP   = 8'h3c;
    localparam int          CTRL_RST    = 0;
    localparam int          CTRL_ABORT  = 1;
    localparam int          CMD_PART    = 0;
    localparam int          CMD_HASSEL  = 1;
    localparam int          CMD_SELB    = 2;
    localparam int          STS_BUSY    = 0;
    localparam int          STS_ERR     = 1;
    localparam int          STS_DONE    = 2;
    typedef enum logic [2:0] {P_IDLE, P_HASH, P_NDIG, P_DIGITS, P_BYTES, P_SHIFT, P_CLEAR} parse_e;
endpackage

/* File: src/user_pattern_store_loader.sv */
// Behaviour
// - Length 1 bit to 8M, stepped granularity
// - Alternate mode: length applies per half
// - Fourteen-character label per store
// - Instrument reset keeps store settings, data
// - Whole_pattern_repeat_use repeats whole; alternate outputs halves
// - Writing use mode sets length one
// - Eight-bit packing: MSB of first byte first
// - Half selector picks half; whole_pattern_repeat_use allows A
// - Header count is always bytes
// - Bits past length dropped (partial writes drop only past count or capacity); growth reads zero
// - Short whole write leaves tail unchanged
// - Capacity 8192 stores 1-4, else 4M
// - Block header hash, digit count, digits
// - Partial write starts at bit, exact count
// - Partial query returns requested bit span
// - Last modification time kept, query only
// - Store 0 working, 1-4 nonvolatile, rest disk
// - Packing 1 or 8, reset to 1
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
module user_pattern_store_loader #(
    parameter int BIG_W      = 22,
    parameter int SMALL_BITS = 8192
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] timeNow,
    input  wire logic        halfSelB,
    output logic             patOut
);
    localparam logic [23:0] CAP_BIG   = 24'h1 << BIG_W;
    localparam logic [23:0] CAP_SMALL = 24'(SMALL_BITS);
    localparam int          NS        = upat_pkg::NUM_STORES;

    typedef struct packed {
        upat_pkg::parse_e               st;
        logic [3:0]                     sel;
        logic                           fmt8;
        logic [NS-1:0][23:0]            len;
        logic [NS-1:0]                  useAlt;
        logic [NS-1:0][13:0][7:0]       label;
        logic [NS-1:0][31:0]            stamp;
        logic                           err;
        logic                           done;
        logic                           partial;
        logic                           halfB;
        logic [23:0]                    start;
        logic [23:0]                    count;
        logic [29:0]                    byteCnt;
        logic [3:0]                     digLeft;
        logic [23:0]                    bitIdx;
        logic [7:0]                     shift;
        logic [3:0]                     shLeft;
        logic [23:0]                    clrPtr;
        logic [23:0]                    clrBeg;
        logic [23:0]                    clrEnd;
        logic                           clrHalfB;
        logic [23:0]                    qPtr;
        logic [23:0]                    outPtr;
        logic                           outHalfB;
        logic                           patOut;
        logic [31:0]                    prdata;
        logic                           pslverr;
    } state_s;

    state_s             q;
    state_s             d;
    logic               mem [0:(16 << BIG_W)-1];
    logic               memWe;
    logic               memBit;
    logic [BIG_W+3:0]   memAddr;
    logic               wrDone;
    logic               rdDone;
    logic               dataTaken;

    function automatic logic [23:0] capOf(input logic [3:0] s);
        return (s >= upat_pkg::NV_FIRST && s <= upat_pkg::NV_LAST) ? CAP_SMALL : CAP_BIG;
    endfunction

    function automatic logic [23:0] limOf(input logic [3:0] s, input logic alt);
        return alt ? (capOf(s) >> 1) : capOf(s);
    endfunction

    function automatic logic lenStepOk(input logic [23:0] l);
        logic ok;
        ok = (l != 24'h0) && (l <= upat_pkg::MAX_LEN);
        for (int k = 0; k < upat_pkg::STEP_ZONES; k++)
            if (l > (upat_pkg::FINE_LIMIT << k))
                ok = ok && ((l & ((24'h2 << k) - 24'h1)) == 24'h0);
        return ok;
    endfunction

    function automatic logic readBit(input logic [3:0] s, input logic [23:0] p);
        return (p < capOf(s)) ? mem[{s, p[BIG_W-1:0]}] : 1'b0;
    endfunction

    assign wrDone    = psel && penable && pready && pwrite;
    assign rdDone    = psel && penable && pready && !pwrite;
    assign dataTaken = wrDone && paddr == upat_pkg::OFF_DATA;
    // Stall stream bytes while an 8-bit byte is still being unpacked or a sweep runs
    assign pready    = !(psel && penable && pwrite && paddr == upat_pkg::OFF_DATA
                         && (q.st == upat_pkg::P_SHIFT || q.st == upat_pkg::P_CLEAR));
    assign prdata    = q.prdata;
    assign pslverr   = q.pslverr;
    assign patOut    = q.patOut;

    always_comb
    begin
        logic [23:0] base;
        logic [23:0] pos;
        logic [23:0] lim;
        logic [7:0]  qb;
        logic        bitGo;
        logic        bitVal;
        logic        fin;
        logic        stop;
        int          c;
        base   = 24'h0;
        pos    = 24'h0;
        lim    = 24'h0;
        qb     = 8'h0;
        bitGo  = 1'b0;
        bitVal = 1'b0;
        fin    = 1'b0;
        // A soft reset or abort must win over the unpacker, or a cut block keeps writing
        stop   = wrDone && paddr == upat_pkg::OFF_CTRL
                 && (pwdata[upat_pkg::CTRL_RST] || pwdata[upat_pkg::CTRL_ABORT]);
        c      = 0;
        d      = q;
        memWe  = 1'b0;
        memBit = 1'b0;
        memAddr = '0;

        // Working store 0 drives the pattern; half changes only at a half boundary
        base = q.outHalfB ? (capOf(4'h0) >> 1) : 24'h0;
        d.patOut = readBit(4'h0, base + q.outPtr);
        if (q.outPtr + 24'h1 >= q.len[0]) begin
            d.outPtr   = 24'h0;
            d.outHalfB = q.useAlt[0] && halfSelB;
        end else
            d.outPtr = q.outPtr + 24'h1;

        if (psel && !penable) begin
            d.prdata  = 32'h0;
            d.pslverr = 1'b0;
            if (paddr == upat_pkg::OFF_SEL)
                d.prdata = {28'h0, q.sel};
            else if (paddr == upat_pkg::OFF_USE)
                d.prdata = {31'h0, q.useAlt[q.sel]};
            else if (paddr == upat_pkg::OFF_LEN)
                d.prdata = {8'h0, q.len[q.sel]};
            else if (paddr >= upat_pkg::OFF_LABEL0 && paddr <= upat_pkg::OFF_LABEL3
                     && paddr[1:0] == 2'b00) begin
                for (int j = 0; j < 4; j++) begin
                    c = 4 * int'(paddr[3:2]) + j;
                    if (c < upat_pkg::LABEL_CHARS)
                        d.prdata[8*j +: 8] = q.label[q.sel][c];
                end
            end else if (paddr == upat_pkg::OFF_FORMAT)
                d.prdata = {28'h0, q.fmt8 ? upat_pkg::PACK8 : upat_pkg::PACK1};
            else if (paddr == upat_pkg::OFF_START)
                d.prdata = {8'h0, q.start};
            else if (paddr == upat_pkg::OFF_COUNT)
                d.prdata = {8'h0, q.count};
            else if (paddr == upat_pkg::OFF_STATUS)
                d.prdata = {29'h0, q.done, q.err, q.st != upat_pkg::P_IDLE};
            else if (paddr == upat_pkg::OFF_QDATA) begin
                base = (q.halfB && q.useAlt[q.sel]) ? (capOf(q.sel) >> 1) : 24'h0;
                for (int i = 0; i < 8; i++) begin
                    pos = q.qPtr + 24'(i);
                    if (pos < q.start + q.count && (q.fmt8 || i == 0))
                        qb[7-i] = readBit(q.sel, base + pos);
                end
                d.prdata = {24'h0, q.fmt8 ? qb : {7'h0, qb[7]}};
            end else if (paddr == upat_pkg::OFF_STAMP)
                d.prdata = q.stamp[q.sel];
            else if (paddr != upat_pkg::OFF_CTRL && paddr != upat_pkg::OFF_CMD
                     && paddr != upat_pkg::OFF_DATA)
                d.pslverr = 1'b1;
        end

        if (rdDone && paddr == upat_pkg::OFF_QDATA)
            d.qPtr = q.qPtr + (q.fmt8 ? 24'h8 : 24'h1);

        if (wrDone) begin
            if (paddr == upat_pkg::OFF_CTRL) begin
                if (pwdata[upat_pkg::CTRL_RST]) begin
                    // Instrument reset touches only transfer state and packing
                    d.st   = upat_pkg::P_IDLE;
                    d.fmt8 = 1'b0;
                    d.err  = 1'b0;
                    d.done = 1'b0;
                end else if (pwdata[upat_pkg::CTRL_ABORT] && q.st != upat_pkg::P_IDLE) begin
                    d.st  = upat_pkg::P_IDLE;
                    d.err = 1'b1;
                end
            end else if (paddr == upat_pkg::OFF_SEL) begin
                if (pwdata[3:0] <= upat_pkg::LAST_STORE && q.st == upat_pkg::P_IDLE)
                    d.sel = pwdata[3:0];
                else
                    d.err = 1'b1;
            end else if (paddr == upat_pkg::OFF_USE) begin
                d.useAlt[q.sel] = pwdata[0];
                d.len[q.sel]    = upat_pkg::LEN_RESET;
                d.stamp[q.sel]  = timeNow;
            end else if (paddr == upat_pkg::OFF_LEN) begin
                lim = limOf(q.sel, q.useAlt[q.sel]);
                if (!lenStepOk(pwdata[23:0]) || pwdata[31:24] != 8'h0
                    || q.st != upat_pkg::P_IDLE)
                    d.err = 1'b1;
                else begin
                    d.len[q.sel]   = pwdata[23:0];
                    d.stamp[q.sel] = timeNow;
                    // Zero newly exposed bits so stale data never reappears
                    if (pwdata[23:0] > q.len[q.sel] && q.len[q.sel] < lim) begin
                        d.st       = upat_pkg::P_CLEAR;
                        d.clrBeg   = q.len[q.sel];
                        d.clrPtr   = q.len[q.sel];
                        d.clrEnd   = (pwdata[23:0] < lim) ? pwdata[23:0] : lim;
                        d.clrHalfB = 1'b0;
                    end
                end
            end else if (paddr >= upat_pkg::OFF_LABEL0 && paddr <= upat_pkg::OFF_LABEL3
                         && paddr[1:0] == 2'b00) begin
                for (int j = 0; j < 4; j++) begin
                    c = 4 * int'(paddr[3:2]) + j;
                    if (c < upat_pkg::LABEL_CHARS)
                        d.label[q.sel][c] = pwdata[8*j +: 8];
                end
                d.stamp[q.sel] = timeNow;
            end else if (paddr == upat_pkg::OFF_FORMAT) begin
                if (pwdata[31:0] == {28'h0, upat_pkg::PACK8})
                    d.fmt8 = 1'b1;
                else if (pwdata[31:0] == {28'h0, upat_pkg::PACK1})
                    d.fmt8 = 1'b0;
                else
                    d.err = 1'b1;
            end else if (paddr == upat_pkg::OFF_START) begin
                d.start = pwdata[23:0];
                d.qPtr  = pwdata[23:0];
            end else if (paddr == upat_pkg::OFF_COUNT)
                d.count = pwdata[23:0];
            else if (paddr == upat_pkg::OFF_CMD) begin
                if (q.st != upat_pkg::P_IDLE
                    || (!q.useAlt[q.sel] && pwdata[upat_pkg::CMD_HASSEL]
                        && pwdata[upat_pkg::CMD_SELB])
                    || (q.useAlt[q.sel] && !pwdata[upat_pkg::CMD_HASSEL]))
                    d.err = 1'b1;
                else begin
                    d.st      = upat_pkg::P_HASH;
                    d.partial = pwdata[upat_pkg::CMD_PART];
                    d.halfB   = pwdata[upat_pkg::CMD_HASSEL] && pwdata[upat_pkg::CMD_SELB];
                    d.bitIdx  = 24'h0;
                    d.done    = 1'b0;
                end
            end
        end

        if (!stop)
        begin
        case (q.st)
            upat_pkg::P_HASH:
                if (dataTaken) begin
                    if (pwdata[7:0] == upat_pkg::CH_HASH)
                        d.st = upat_pkg::P_NDIG;
                    else begin
                        d.st  = upat_pkg::P_IDLE;
                        d.err = 1'b1;
                    end
                end
            upat_pkg::P_NDIG:
                if (dataTaken) begin
                    if (pwdata[7:0] >= upat_pkg::CH_1 && pwdata[7:0] <= upat_pkg::CH_9) begin
                        d.st      = upat_pkg::P_DIGITS;
                        d.digLeft = 4'(pwdata[7:0] - upat_pkg::CH_0);
                        d.byteCnt = 30'h0;
                    end else begin
                        d.st  = upat_pkg::P_IDLE;
                        d.err = 1'b1;
                    end
                end
            upat_pkg::P_DIGITS:
                if (dataTaken) begin
                    if (pwdata[7:0] >= upat_pkg::CH_0 && pwdata[7:0] <= upat_pkg::CH_9) begin
                        // Count is bytes whatever the packing
                        d.byteCnt = 30'(q.byteCnt * 30'd10 + 30'(pwdata[7:0] - upat_pkg::CH_0));
                        d.digLeft = q.digLeft - 4'h1;
                        if (q.digLeft == 4'h1)
                            d.st = (d.byteCnt == 30'h0) ? upat_pkg::P_IDLE : upat_pkg::P_BYTES;
                    end else begin
                        d.st  = upat_pkg::P_IDLE;
                        d.err = 1'b1;
                    end
                end
            upat_pkg::P_BYTES:
                if (dataTaken) begin
                    d.byteCnt = q.byteCnt - 30'h1;
                    if (q.fmt8) begin
                        bitGo   = 1'b1;
                        bitVal  = pwdata[7];
                        d.shift = {pwdata[6:0], 1'b0};
                        d.shLeft = 4'h7;
                        d.st    = upat_pkg::P_SHIFT;
                    end else begin
                        bitGo  = 1'b1;
                        bitVal = pwdata[0];
                        fin    = (q.byteCnt == 30'h1);
                    end
                end
            upat_pkg::P_SHIFT:
            begin
                bitGo   = 1'b1;
                bitVal  = q.shift[7];
                d.shift = {q.shift[6:0], 1'b0};
                d.shLeft = q.shLeft - 4'h1;
                if (q.shLeft == 4'h1) begin
                    if (q.byteCnt == 30'h0)
                        fin = 1'b1;
                    else
                        d.st = upat_pkg::P_BYTES;
                end
            end
            upat_pkg::P_CLEAR:
            begin
                base    = q.clrHalfB ? (capOf(q.sel) >> 1) : 24'h0;
                memWe   = 1'b1;
                memBit  = 1'b0;
                pos     = base + q.clrPtr;
                memAddr = {q.sel, pos[BIG_W-1:0]};
                d.clrPtr = q.clrPtr + 24'h1;
                if (q.clrPtr + 24'h1 >= q.clrEnd) begin
                    if (q.useAlt[q.sel] && !q.clrHalfB) begin
                        d.clrHalfB = 1'b1;
                        d.clrPtr   = q.clrBeg;
                    end else
                        d.st = upat_pkg::P_IDLE;
                end
            end
            default: ;
        endcase
        end

        if (bitGo) begin
            lim    = limOf(q.sel, q.useAlt[q.sel]);
            base   = q.halfB ? (capOf(q.sel) >> 1) : 24'h0;
            pos    = (q.partial ? q.start : 24'h0) + q.bitIdx;
            memBit = bitVal;
            // Only delivered bits are written, so the tail keeps its contents
            if ((q.partial ? q.bitIdx < q.count : q.bitIdx < q.len[q.sel]) && pos < lim) begin
                memWe   = 1'b1;
                pos     = base + pos;
                memAddr = {q.sel, pos[BIG_W-1:0]};
            end
            d.bitIdx = q.bitIdx + 24'h1;
        end
        if (fin) begin
            d.st           = upat_pkg::P_IDLE;
            d.done         = 1'b1;
            d.stamp[q.sel] = timeNow;
        end
        if (dataTaken && q.st == upat_pkg::P_IDLE)
            d.err = 1'b1;

        if (!reset_n) begin
            d     = '0;
            d.len = {NS{upat_pkg::LEN_RESET}};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        q <= d;
    end

    // Pattern memory has no reset: contents survive any reset
    always_ff @(posedge ref_clk)
    begin
        if (memWe)
            mem[memAddr] <= memBit;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_use_wr;
        wrDone && paddr == upat_pkg::OFF_USE;
    endsequence
    sequence s_soft_rst;
        wrDone && paddr == upat_pkg::OFF_CTRL && pwdata[upat_pkg::CTRL_RST];
    endsequence
    sequence s_byte8;
        dataTaken && q.st == upat_pkg::P_BYTES && q.fmt8;
    endsequence

    a_len_step: assert property (lenStepOk(q.len[q.sel]))
        else $error("length off step grid");
    a_use_len_one: assert property (s_use_wr |=> q.len[$past(q.sel)] == 24'h1)
        else $error("use write did not reset length");
    a_use_stamp: assert property (s_use_wr |=> q.stamp[$past(q.sel)] == $past(timeNow))
        else $error("timestamp not updated");
    a_soft_keep: assert property (s_soft_rst |=> q.len == $past(q.len)
                                  && q.label == $past(q.label) && q.useAlt == $past(q.useAlt)
                                  && !q.fmt8 && q.st == upat_pkg::P_IDLE)
        else $error("soft reset changed store settings");
    a_fmt_legal: assert property (wrDone && paddr == upat_pkg::OFF_FORMAT
                                  && pwdata[3:0] != upat_pkg::PACK1
                                  && pwdata[3:0] != upat_pkg::PACK8 |=> q.fmt8 == $past(q.fmt8))
        else $error("illegal packing accepted");
    a_msb_first: assert property (s_byte8 |-> memBit == pwdata[7] ##1
                                  memBit == $past(pwdata[6]) ##1 memBit == $past(pwdata[5], 2))
        else $error("packed bits out of order");
    a_drop_beyond: assert property (memWe && q.st != upat_pkg::P_CLEAR
                                    |-> (q.partial ? q.bitIdx < q.count : q.bitIdx < q.len[q.sel]))
        else $error("bit written past length or count");
    a_bad_header: assert property (dataTaken && q.st == upat_pkg::P_HASH
                                   && pwdata[7:0] != upat_pkg::CH_HASH |=> (q.err && !memWe)[*2])
        else $error("malformed header not rejected");
    a_clear_zero: assert property (q.st == upat_pkg::P_CLEAR && memWe |-> !memBit)
        else $error("sweep wrote a one");
endmodule // user_pattern_store_loader

/* File: testbench/pattern_env_model.sv */
`timescale 1ns/10ps
module pattern_env_model (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    output logic      [31:0] timeNow,
    output logic             halfSelB
);
    // Time code never sits at zero, so a stamp of zero means never modified
    always @(posedge ref_clk)
    begin
        timeNow  <= reset_n ? timeNow + 32'h1 : 32'h1;
        halfSelB <= timeNow[3];
    end
endmodule // pattern_env_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin failCount++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic        ref_clk   = 1'b0;
    logic        reset_n   = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata;
    logic [31:0] timeNow;
    logic [31:0] rdat;
    logic        pready;
    logic        pslverr;
    logic        halfSelB;
    logic        lastErr;
    logic        patOut;
    logic [3:0]  pv;
    logic [31:0] t0;
    logic [8:0]  bitsExp   = 9'h1d1;
    int          failCount = 0;
    int          nTests    = 0;

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    user_pattern_store_loader #(.BIG_W(10), .SMALL_BITS(256)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timeNow(timeNow), .halfSelB(halfSelB),
        .patOut(patOut));
    pattern_env_model env_u (.ref_clk(ref_clk), .reset_n(reset_n), .timeNow(timeNow),
        .halfSelB(halfSelB));

    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'b1;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Read at the edge before its updates land: the values the slave saw
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat    = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ex);
        xfer(a, 1'b0, 32'h0);
        `CHK($sformatf("read %h", a), ex, rdat)
    endtask
    task waitIdle;
        do xfer(upat_pkg::OFF_STATUS, 1'b0, 32'h0); while (rdat[0] !== 1'b0);
    endtask
    task blk(input logic [7:0] b0, input logic [7:0] b1);
        wr(upat_pkg::OFF_DATA, {24'h0, upat_pkg::CH_HASH});
        wr(upat_pkg::OFF_DATA, {24'h0, upat_pkg::CH_1});
        wr(upat_pkg::OFF_DATA, 32'h32);
        wr(upat_pkg::OFF_DATA, {24'h0, b0});
        wr(upat_pkg::OFF_DATA, {24'h0, b1});
        waitIdle;
    endtask
    task finish_test;
        $display("Checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        failCount++;
        $display("FAIL watchdog expected 1 seen 0");
        finish_test;
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        wr(upat_pkg::OFF_SEL, 32'h5);
        rd(upat_pkg::OFF_LEN, 32'h1);
        wr(upat_pkg::OFF_FORMAT, 32'h3);
        rd(upat_pkg::OFF_FORMAT, 32'h1);
        xfer(8'h40, 1'b0, 32'h0);
        `CHK("pslverr", 1'b1, lastErr)
        wr(upat_pkg::OFF_LABEL3, 32'hffff6e6d);
        rd(upat_pkg::OFF_LABEL3, 32'h00006e6d);
        wr(upat_pkg::OFF_LEN, 32'h8001);
        rd(upat_pkg::OFF_LEN, 32'h1);
        rd(upat_pkg::OFF_STATUS, 32'h2);
        wr(upat_pkg::OFF_LEN, 32'h8002);
        waitIdle;
        rd(upat_pkg::OFF_LEN, 32'h8002);
        wr(upat_pkg::OFF_FORMAT, 32'h8);
        wr(upat_pkg::OFF_CTRL, 32'h1);
        rd(upat_pkg::OFF_FORMAT, 32'h1);
        rd(upat_pkg::OFF_LEN, 32'h8002);
        rd(upat_pkg::OFF_LABEL3, 32'h00006e6d);
        rd(upat_pkg::OFF_STATUS, 32'h0);
        $display("test settings done");
        wr(upat_pkg::OFF_USE, 32'h0);
        rd(upat_pkg::OFF_LEN, 32'h1);
        wr(upat_pkg::OFF_LEN, 32'h9);
        waitIdle;
        wr(upat_pkg::OFF_FORMAT, 32'h8);
        wr(upat_pkg::OFF_CMD, 32'h2);
        blk(8'h9b, 8'hff);
        rd(upat_pkg::OFF_STATUS, 32'h4);
        wr(upat_pkg::OFF_START, 32'h0);
        wr(upat_pkg::OFF_COUNT, 32'h10);
        rd(upat_pkg::OFF_QDATA, 32'h9b);
        rd(upat_pkg::OFF_QDATA, 32'h80);
        $display("test whole write done");
        wr(upat_pkg::OFF_FORMAT, 32'h1);
        wr(upat_pkg::OFF_START, 32'h3);
        wr(upat_pkg::OFF_COUNT, 32'h2);
        wr(upat_pkg::OFF_CMD, 32'h3);
        blk(8'h00, 8'h01);
        wr(upat_pkg::OFF_START, 32'h0);
        wr(upat_pkg::OFF_COUNT, 32'h9);
        for (int i = 0; i < 9; i++)
            rd(upat_pkg::OFF_QDATA, {31'h0, bitsExp[i]});
        $display("test partial write done");
        wr(upat_pkg::OFF_LEN, 32'h10);
        waitIdle;
        wr(upat_pkg::OFF_FORMAT, 32'h8);
        wr(upat_pkg::OFF_START, 32'h8);
        wr(upat_pkg::OFF_COUNT, 32'h8);
        rd(upat_pkg::OFF_QDATA, 32'h80);
        $display("test length growth done");
        wr(upat_pkg::OFF_CMD, 32'h0);
        wr(upat_pkg::OFF_DATA, 32'h41);
        rd(upat_pkg::OFF_STATUS, 32'h2);
        wr(upat_pkg::OFF_CTRL, 32'h1);
        wr(upat_pkg::OFF_USE, 32'h1);
        wr(upat_pkg::OFF_LEN, 32'h4);
        waitIdle;
        wr(upat_pkg::OFF_CMD, 32'h0);
        rd(upat_pkg::OFF_STATUS, 32'h2);
        wr(upat_pkg::OFF_CMD, 32'h6);
        blk(8'h00, 8'h01);
        wr(upat_pkg::OFF_START, 32'h0);
        wr(upat_pkg::OFF_COUNT, 32'h2);
        rd(upat_pkg::OFF_QDATA, 32'h0);
        rd(upat_pkg::OFF_QDATA, 32'h1);
        $display("test header and alternate done");
        wr(upat_pkg::OFF_SEL, 32'h0);
        wr(upat_pkg::OFF_USE, 32'h0);
        wr(upat_pkg::OFF_LEN, 32'h2);
        waitIdle;
        wr(upat_pkg::OFF_CMD, 32'h0);
        t0 = timeNow;
        blk(8'h01, 8'h00);
        repeat (4) @(posedge ref_clk) pv = {pv[2:0], patOut};
        `CHK("patOut", 1'b1, pv == 4'ha || pv == 4'h5)
        xfer(upat_pkg::OFF_STAMP, 1'b0, 32'h0);
        `CHK("stamp", 1'b1, rdat > t0 && rdat < timeNow)
        wr(upat_pkg::OFF_SEL, 32'hc);
        rd(upat_pkg::OFF_STAMP, 32'h0);
        $display("test pattern output done");
        finish_test;
    end
endmodule // testbench
